// File: rtl/dma_chan_cfg.svh
// Offsets, field positions, reset values and codes for the channel status slice
`ifndef DMA_CHAN_CFG_SVH
`define DMA_CHAN_CFG_SVH

`define NUM_CHANNELS 8
`define CHAN_ID_W 3
`define ADDR_W 8
`define DATA_W 8

`define OFF_CHANNEL_SELECT 8'h3F
`define OFF_CHANNEL_CONTROL_B 8'h48
`define OFF_CHANNEL_IRQ_ENABLE_CLEAR 8'h4C
`define OFF_CHANNEL_IRQ_ENABLE_SET 8'h4D
`define OFF_CHANNEL_IRQ_FLAGS 8'h4E
`define OFF_CHANNEL_STATE 8'h4F

`define BIT_SUSPEND 2
`define BIT_COMPLETE 1
`define BIT_ERROR 0
`define BIT_FETCH_ERROR 2
`define BIT_BUSY 1
`define BIT_WAITING 0
`define BIT_EVENT_INPUT_ENABLE 3

`define ENABLE_RESET 3'h0
`define FLAGS_RESET 3'h0
`define STATE_RESET 3'h0
`define CTRLB_RESET 4'h0

`define BLOCK_ACTION_NONE 2'h0
`define BLOCK_ACTION_INT 2'h1
`define BLOCK_ACTION_SUSPEND 2'h2
`define BLOCK_ACTION_BOTH 2'h3

`endif

// File: rtl/dma_chan_pkg.sv
// Types shared by the channel status slice
package dma_chan_pkg;
    typedef enum logic [2:0] {
        no_action_code = 3'h0,
        normal_trigger_action = 3'h1,
        conditional_transfer_action = 3'h2,
        conditional_block_action = 3'h3,
        suspend_action = 3'h4,
        resume_action = 3'h5,
        skip_next_suspend_action = 3'h6,
        reserved_action = 3'h7
    } event_input_action_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] block_done;
        logic [15:0] block_action;
        logic [7:0] bus_error;
        logic [7:0] bad_descriptor;
        logic [7:0] sw_suspend;
        logic [7:0] sw_resume;
        logic [7:0] request;
        logic [7:0] trigger_start;
        logic [7:0] trigger_end;
        logic [7:0] disable_chan;
        logic [7:0] event_in;
    } chan_events_s;

    typedef struct packed {
        logic normal_trigger;
        logic conditional_transfer;
        logic conditional_block;
        logic suspend;
        logic resume;
        logic skip_suspend;
    } event_cmds_s;
endpackage

// File: rtl/event_action_decoder.sv
// Decodes one channel event input into a single action pulse
`timescale 1ns/1ps
module event_action_decoder (
    input wire logic event_pulse,
    input wire logic event_input_enable,
    input wire dma_chan_pkg::event_input_action_e event_input_action,
    output dma_chan_pkg::event_cmds_s cmds
);
    import dma_chan_pkg::*;

    logic fire;

    assign fire = event_pulse & event_input_enable; // RL3

    always_comb begin
        cmds = '0;
        if (fire) begin
            unique case (event_input_action)
                no_action_code: cmds = '0; // RL1
                normal_trigger_action: cmds.normal_trigger = 1'b1; // RL1
                conditional_transfer_action: cmds.conditional_transfer = 1'b1; // RL1
                conditional_block_action: cmds.conditional_block = 1'b1; // RL1
                suspend_action: cmds.suspend = 1'b1; // RL2
                resume_action: cmds.resume = 1'b1; // RL2
                skip_next_suspend_action: cmds.skip_suspend = 1'b1; // RL2
                reserved_action: cmds = '0; // RL2
            endcase
        end
    end
endmodule

// File: rtl/channel_flag_bit.sv
// Sticky status bit whose set outranks its clear
`timescale 1ns/1ps
module channel_flag_bit (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic value
);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            value <= 1'b0;
        end else if (set_pulse) begin
            value <= 1'b1;
        end else if (clear_pulse) begin
            value <= 1'b0;
        end
    end
endmodule

// File: rtl/dma_channel_event_irq_status.sv
// Per-channel event action, interrupt enable, flag and status registers
`timescale 1ns/1ps
`include "dma_chan_cfg.svh"

// Operation
// RL1: Event codes 0..3: none, normal trigger, conditional transfer, conditional block.
// RL2: Event codes 4..6: suspend, resume, skip next suspend; code 7 reserved.
// RL3: Event actions run only when the channel event input enable is set.
// RL4: Enable, flag and status registers address the selected channel.
// RL5: Enable-clear write clears bits written one; reads show shared enables.
// RL6: Enable-set write sets bits written one; visible via enable-clear too.
// RL7: Enable bits: 2 suspend, 1 complete, 0 error; reset zero.
// RL8: Complete enable clear and block action none: no complete flag.
// RL9: Suspend flag on suspend block, software suspend, suspend event, bad descriptor.
// RL10: Complete flag when block finishes with interrupt block action.
// RL11: Error flag on bus error or invalid descriptor fetch.
// RL12: Flags bits 2..0 cleared by writing one; reset zero.
// RL13: Fetch error set on bad descriptor, cleared only by software resume.
// RL14: Busy set on transfer start; cleared on trigger end, bus error, disable.
// RL15: Waiting set on request; cleared on trigger start, bus error, disable.
// RL16: Interrupt request while any flag and its enable are both set.
module dma_channel_event_irq_status (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire dma_chan_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire dma_chan_pkg::chan_events_s events,
    input wire logic [7:0] transfer_start,
    output logic [7:0] irq_req,
    output logic [7:0] suspend_cmd,
    output logic [7:0] resume_cmd,
    output logic [7:0] skip_suspend_cmd,
    output logic [7:0] trigger_cmd,
    output logic [7:0] cond_transfer_cmd,
    output logic [7:0] cond_block_cmd
);
    import dma_chan_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic [2:0] channel_select_reg;
    logic [3:0] ctrlb_reg [0:`NUM_CHANNELS-1];
    logic [2:0] enable_reg [0:`NUM_CHANNELS-1];
    logic [2:0] flags [0:`NUM_CHANNELS-1];
    logic [2:0] state [0:`NUM_CHANNELS-1];
    logic [7:0] reg_rdata_next;

    logic wr_sel;
    logic wr_ctrlb;
    logic wr_en_clr;
    logic wr_en_set;
    logic wr_flags;

    assign wr_sel = reg_req.write & hit(reg_req.addr, `OFF_CHANNEL_SELECT);
    assign wr_ctrlb = reg_req.write & hit(reg_req.addr, `OFF_CHANNEL_CONTROL_B);
    assign wr_en_clr = reg_req.write & hit(reg_req.addr, `OFF_CHANNEL_IRQ_ENABLE_CLEAR);
    assign wr_en_set = reg_req.write & hit(reg_req.addr, `OFF_CHANNEL_IRQ_ENABLE_SET);
    assign wr_flags = reg_req.write & hit(reg_req.addr, `OFF_CHANNEL_IRQ_FLAGS);

    // ----------------------------------------
    // Channel select
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            channel_select_reg <= 3'h0;
        end else if (wr_sel) begin
            channel_select_reg <= reg_req.wdata[2:0];
        end
    end

    // ----------------------------------------
    // Per-channel logic
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_chan
            logic selected;
            event_cmds_s cmds;
            logic [1:0] bact;
            logic tc_allowed;
            logic fetch_bad;

            assign selected = (channel_select_reg == 3'(ch)); // RL4
            assign bact = events.block_action[2*ch +: 2];
            assign fetch_bad = events.bad_descriptor[ch];

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    ctrlb_reg[ch] <= `CTRLB_RESET;
                end else if (wr_ctrlb & selected) begin
                    ctrlb_reg[ch] <= reg_req.wdata[3:0];
                end
            end

            event_action_decoder u_dec (
                .event_pulse(events.event_in[ch]),
                .event_input_enable(ctrlb_reg[ch][`BIT_EVENT_INPUT_ENABLE]), // RL3
                .event_input_action(event_input_action_e'(ctrlb_reg[ch][2:0])),
                .cmds(cmds)
            );

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    enable_reg[ch] <= `ENABLE_RESET; // RL7
                end else if (selected & wr_en_set) begin
                    enable_reg[ch] <= enable_reg[ch] | reg_req.wdata[2:0]; // RL6
                end else if (selected & wr_en_clr) begin
                    enable_reg[ch] <= enable_reg[ch] & ~reg_req.wdata[2:0]; // RL5
                end
            end

            // Complete is gated off when its enable is clear and block action is none
            assign tc_allowed = bact[0] &
                ~(~enable_reg[ch][`BIT_COMPLETE] & (bact == `BLOCK_ACTION_NONE)); // RL8

            channel_flag_bit u_suspend_flag (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse((events.block_done[ch] & bact[1]) | events.sw_suspend[ch] |
                    cmds.suspend | fetch_bad), // RL9
                .clear_pulse(selected & wr_flags & reg_req.wdata[`BIT_SUSPEND]), // RL12
                .value(flags[ch][`BIT_SUSPEND])
            );
            channel_flag_bit u_tc (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse(events.block_done[ch] & tc_allowed), // RL10
                .clear_pulse(selected & wr_flags & reg_req.wdata[`BIT_COMPLETE]), // RL12
                .value(flags[ch][`BIT_COMPLETE])
            );
            channel_flag_bit u_err (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse(events.bus_error[ch] | fetch_bad), // RL11
                .clear_pulse(selected & wr_flags & reg_req.wdata[`BIT_ERROR]), // RL12
                .value(flags[ch][`BIT_ERROR])
            );
            channel_flag_bit u_fetch_error_bit (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse(fetch_bad), // RL13
                .clear_pulse(events.sw_resume[ch]), // RL13
                .value(state[ch][`BIT_FETCH_ERROR])
            );
            channel_flag_bit u_busy (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse(transfer_start[ch]), // RL14
                .clear_pulse(events.trigger_end[ch] | events.bus_error[ch] |
                    events.disable_chan[ch]), // RL14
                .value(state[ch][`BIT_BUSY])
            );
            channel_flag_bit u_wait (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .set_pulse(events.request[ch]), // RL15
                .clear_pulse(events.trigger_start[ch] | events.bus_error[ch] |
                    events.disable_chan[ch]), // RL15
                .value(state[ch][`BIT_WAITING])
            );

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    irq_req[ch] <= 1'b0;
                    suspend_cmd[ch] <= 1'b0;
                    resume_cmd[ch] <= 1'b0;
                    skip_suspend_cmd[ch] <= 1'b0;
                    trigger_cmd[ch] <= 1'b0;
                    cond_transfer_cmd[ch] <= 1'b0;
                    cond_block_cmd[ch] <= 1'b0;
                end else begin
                    irq_req[ch] <= |(flags[ch] & enable_reg[ch]); // RL16
                    suspend_cmd[ch] <= cmds.suspend; // RL2
                    resume_cmd[ch] <= cmds.resume; // RL2
                    skip_suspend_cmd[ch] <= cmds.skip_suspend; // RL2
                    trigger_cmd[ch] <= cmds.normal_trigger; // RL1
                    cond_transfer_cmd[ch] <= cmds.conditional_transfer; // RL1
                    cond_block_cmd[ch] <= cmds.conditional_block; // RL1
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        reg_rdata_next = 8'h00;
        if (reg_req.read) begin
            unique case (reg_req.addr)
                `OFF_CHANNEL_SELECT: reg_rdata_next = {5'h00, channel_select_reg};
                `OFF_CHANNEL_CONTROL_B: reg_rdata_next = {4'h0, ctrlb_reg[channel_select_reg]};
                `OFF_CHANNEL_IRQ_ENABLE_CLEAR,
                `OFF_CHANNEL_IRQ_ENABLE_SET:
                    reg_rdata_next = {5'h00, enable_reg[channel_select_reg]}; // RL5
                `OFF_CHANNEL_IRQ_FLAGS: reg_rdata_next = {5'h00, flags[channel_select_reg]};
                `OFF_CHANNEL_STATE: reg_rdata_next = {5'h00, state[channel_select_reg]}; // RL4
                default: reg_rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rdata_next;
        end
    end
endmodule

// File: sim/dma_chan_checker_assertions.sv
// Port checker for the channel status slice
`timescale 1ns/1ps
module dma_chan_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire dma_chan_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire dma_chan_pkg::chan_events_s events,
    input wire logic [7:0] transfer_start,
    input wire logic [7:0] irq_req,
    input wire logic [7:0] suspend_cmd,
    input wire logic [7:0] resume_cmd,
    input wire logic [7:0] skip_suspend_cmd,
    input wire logic [7:0] trigger_cmd,
    input wire logic [7:0] cond_transfer_cmd,
    input wire logic [7:0] cond_block_cmd
);
    import dma_chan_pkg::*;
    // ----
    // Shadow of select and enables
    // ----
    logic [2:0] sel_sh;
    logic [2:0] en_sh [8];
    wire logic [7:0] any_cmd = suspend_cmd | resume_cmd | skip_suspend_cmd | trigger_cmd
        | cond_transfer_cmd | cond_block_cmd;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_sh <= 3'h0;
            en_sh <= '{default: 3'h0};
        end else if (reg_req.write) begin
            if (reg_req.addr == 8'h3F) sel_sh <= reg_req.wdata[2:0];
            if (reg_req.addr == 8'h4D) en_sh[sel_sh] <= en_sh[sel_sh] | reg_req.wdata[2:0];
            if (reg_req.addr == 8'h4C) en_sh[sel_sh] <= en_sh[sel_sh] & ~reg_req.wdata[2:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_en_read;
        reg_req.read && (reg_req.addr == 8'h4C || reg_req.addr == 8'h4D);
    endsequence
    sequence s_odd_read;
        reg_req.read && !(reg_req.addr inside {8'h3F, 8'h48, [8'h4C:8'h4F]});
    endsequence
    a_rdata_idle_zero: assert property (
        !$past(reg_req.read) |-> reg_rdata == 8'h00) else $error("read data outside answer");
    a_enable_readback: assert property (
        s_en_read |=> reg_rdata == {5'h00, $past(en_sh[sel_sh])}) else $error("enable readback");
    a_unmapped_zero: assert property (
        s_odd_read |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_cmd_needs_event: assert property (
        any_cmd != 8'h00 |-> (any_cmd & ~$past(events.event_in)) == 8'h00)
        else $error("command without event");
    for (genvar c = 0; c < 8; c++) begin : g_ch
        a_cmd_onehot: assert property (
            $onehot0({suspend_cmd[c], resume_cmd[c], skip_suspend_cmd[c], trigger_cmd[c],
            cond_transfer_cmd[c], cond_block_cmd[c]})) else $error("two commands at once");
        a_irq_needs_enable: assert property (
            irq_req[c] |-> $past(en_sh[c]) != 3'h0) else $error("request without enable");
        a_error_raises_irq: assert property (
            events.bus_error[c] && en_sh[c][0] |-> ##[1:3] irq_req[c]) else $error("no error irq");
        a_suspend_raises_irq: assert property (
            events.sw_suspend[c] && en_sh[c][2] |-> ##[1:3] irq_req[c]) else $error("no suspend_flag irq");
    end
endmodule
bind dma_channel_event_irq_status dma_chan_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .events(events), .transfer_start(transfer_start),
    .irq_req(irq_req), .suspend_cmd(suspend_cmd), .resume_cmd(resume_cmd),
    .skip_suspend_cmd(skip_suspend_cmd), .trigger_cmd(trigger_cmd),
    .cond_transfer_cmd(cond_transfer_cmd), .cond_block_cmd(cond_block_cmd));

// File: sim/event_source.sv
// Model of the controller event sources
`timescale 1ns/1ps
module event_source (
    input wire logic sys_clk,
    output dma_chan_pkg::chan_events_s events,
    output logic [7:0] transfer_start
);
    import dma_chan_pkg::*;
    logic [10:0][7:0] p = '0;
    logic [15:0] act = 16'h0000;
    assign events = {p[0], act, p[1], p[2], p[3], p[4], p[5], p[6], p[7], p[8], p[9]};
    assign transfer_start = p[10];
    task automatic fire(int k, int ch);
        @(posedge sys_clk);
        p[k][ch] <= 1'b1;
        @(posedge sys_clk);
        p[k][ch] <= 1'b0;
    endtask
    task automatic set_action(int ch, logic [1:0] a);
        @(posedge sys_clk);
        act[2*ch +: 2] <= a;
    endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the channel status slice
`timescale 1ns/1ps
module tb;
    import dma_chan_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_s reg_req = '0;
    logic [7:0] reg_rdata, irq_req, sc, rc, kc, tc, cc, bc, transfer_start;
    chan_events_s events;
    int failures = 0;
    int n_checks = 0;
    int clr[3] = '{7, 1, 8};
    logic [7:0] exp_cmd[8] = '{8'h00, 8'h04, 8'h02, 8'h01, 8'h20, 8'h10, 8'h08, 8'h00};
    always #4 sys_clk = ~sys_clk;
    event_source src (.sys_clk(sys_clk), .events(events), .transfer_start(transfer_start));
    dma_channel_event_irq_status uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .events(events), .transfer_start(transfer_start),
        .irq_req(irq_req), .suspend_cmd(sc), .resume_cmd(rc), .skip_suspend_cmd(kc),
        .trigger_cmd(tc), .cond_transfer_cmd(cc), .cond_block_cmd(bc));
    task automatic check(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        reg_req.write <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        reg_req.read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wr(8'h3F, 8'h02);
        for (int a = 8'h4C; a <= 8'h4F; a++) rd(8'(a), 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h4D, 8'h07);
        rd(8'h4C, 8'h07);
        wr(8'h4C, 8'h02);
        rd(8'h4D, 8'h05);
        $display("test enables done");
        src.fire(1, 2);
        rd(8'h4E, 8'h01);
        check(irq_req, 8'h04);
        wr(8'h4E, 8'h00);
        rd(8'h4E, 8'h01);
        wr(8'h4E, 8'h01);
        rd(8'h4E, 8'h00);
        check(irq_req, 8'h00);
        src.fire(2, 2);
        rd(8'h4E, 8'h05);
        wr(8'h4E, 8'h05);
        rd(8'h4F, 8'h04);
        src.fire(4, 2);
        rd(8'h4F, 8'h00);
        $display("test flags done");
        for (int i = 0; i < 3; i++) begin
            src.fire(10, 2);
            src.fire(5, 2);
            rd(8'h4F, 8'h03);
            src.fire(clr[i], 2);
            rd(8'h4F, i == 0 ? 8'h01 : 8'h00);
            src.fire(6, 2);
            rd(8'h4F, 8'h00);
        end
        $display("test state done");
        wr(8'h4E, 8'h07);
        for (int a = 0; a < 4; a++) begin
            src.set_action(2, 2'(a));
            src.fire(0, 2);
            rd(8'h4E, 8'(a * 2));
            wr(8'h4E, 8'h07);
        end
        src.fire(3, 2);
        rd(8'h4E, 8'h04);
        wr(8'h4E, 8'h07);
        $display("test blocks done");
        for (int k = 0; k < 8; k++) begin
            wr(8'h48, 8'(8 + k));
            src.fire(9, 2);
            #1;
            check({2'b00, sc[2], rc[2], kc[2], tc[2], cc[2], bc[2]}, exp_cmd[k]);
        end
        rd(8'h4E, 8'h04);
        wr(8'h48, 8'h04);
        src.fire(9, 2);
        #1;
        check(sc | rc | kc | tc | cc | bc, 8'h00);
        rd(8'h48, 8'h04);
        $display("test events done");
        wr(8'h3F, 8'h05);
        rd(8'h3F, 8'h05);
        rd(8'h4E, 8'h00);
        rd(8'h4C, 8'h00);
        src.fire(1, 5);
        rd(8'h4E, 8'h01);
        check(irq_req, 8'h04);
        wr(8'h3F, 8'h02);
        rd(8'h4E, 8'h04);
        $display("test select done");
        complete_run();
    end
endmodule
